// ---- src/mse_mains_eval.v ----
// Mains status evaluator: per-phase bands, global status, presence/absence delays, events, APB registers.
// Assumes measurement inputs synchronous to clk_i and already scaled to volts and hundredths of hertz.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "mse_defs.vh"

module mse_mains_eval #(
  parameter integer TICK_CYCLES = `MSE_TICK_CYC,
  parameter integer VW          = 16
) (
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [7:0]    paddr_i,
  input  wire [31:0]   pwdata_i,
  output wire [31:0]   prdata_o,
  output wire          pready_o,
  output wire          pslverr_o,
  input  wire [3*VW-1:0] volt_i,
  input  wire [VW-1:0] freq_i,
  input  wire          rot_cw_i,
  input  wire          external_mains_sensor_input,
  input  wire          mode_off_i,
  input  wire          mode_auto_i,
  input  wire          gen_feeding_i,
  output wire          mains_ok_output,
  output wire          flag_mains_present,
  output wire          flag_mains_bad_or_absent,
  output wire          flag_delay_to_good,
  output wire          flag_mains_good,
  output wire          flag_delay_to_bad,
  output wire          event_mains_lost,
  output wire          event_mains_out_of_tol,
  output wire          event_mains_in_tol,
  output wire          irq_o
);

  localparam [1:0] S_BAD = 2'h0;
  localparam [1:0] S_TO_GOOD = 2'h1;
  localparam [1:0] S_GOOD = 2'h2;
  localparam [1:0] S_TO_BAD = 2'h3;

  // Band with hysteresis: inside a hysteresis zone the previous band is kept
  function [1:0] band;
    input [1:0]    prev;
    input [VW-1:0] val;
    input [VW-1:0] pres;
    input [VW-1:0] hys;
    input [VW-1:0] lo;
    input [VW-1:0] hi;
    reg   [VW:0]   pres_lo;
    reg   [VW:0]   lo_hi;
    reg   [VW:0]   hi_lo;
    begin
      pres_lo = (pres > hys) ? {1'b0, pres - hys} : {(VW+1){1'b0}};
      lo_hi   = {1'b0, lo} + {1'b0, hys};
      hi_lo   = (hi > hys) ? {1'b0, hi - hys} : {(VW+1){1'b0}};
      if ({1'b0, val} < pres_lo)
        band = `MSE_ST_ABSENT;
      else if (val < pres)
        band = prev;
      else if (val < lo)
        band = `MSE_ST_LOW;
      else if ({1'b0, val} < lo_hi)
        band = prev;
      else if ({1'b0, val} <= hi_lo)
        band = `MSE_ST_OK;
      else if (val <= hi)
        band = prev;
      else
        band = `MSE_ST_HIGH;
    end
  endfunction

  function [VW-1:0] absdiff;
    input [VW-1:0] a;
    input [VW-1:0] b;
    begin
      absdiff = (a > b) ? a - b : b - a;
    end
  endfunction

  // Registers
  reg  [7:0]    ctrl_ff;
  reg  [15:0]   vrated_ff;
  reg  [9:0]    asym_ff;
  reg  [31:0]   vpres_ff;
  reg  [31:0]   vlim_ff;
  reg  [31:0]   fpres_ff;
  reg  [31:0]   flim_ff;
  reg  [31:0]   dly_ff;
  reg  [2:0]    irq_stat_ff;
  reg  [2:0]    irq_en_ff;
  reg  [31:0]   prdata_ff;
  reg  [2*3-1:0] vband_ff;
  reg  [1:0]    fband_ff;
  reg  [1:0]    state_ff;
  reg  [15:0]   dcnt_ff;
  reg  [31:0]   tick_cnt_ff;
  reg  [1:0]    class_ff;
  reg  [2:0]    evt_ff;

  reg  [2*3-1:0] nxt_vband;
  reg  [1:0]    nxt_fband;
  reg  [1:0]    int_st;
  reg  [1:0]    glob_st;
  reg  [2:0]    act;
  reg           all_abs;
  reg           all_ok;
  reg           any_high;
  reg  [VW-1:0] dmax;
  reg  [1:0]    nxt_state;
  reg  [15:0]   nxt_dcnt;
  reg  [1:0]    nxt_class;
  reg  [31:0]   rd_mux;
  reg           rd_hit;
  integer       i, j;

  wire          multi_ph = (ctrl_ff[`MSE_CTRL_PH_LSB +: 2] >= 2'h2);
  wire [1:0]    rot_req  = ctrl_ff[`MSE_CTRL_ROT_LSB +: 2];
  wire          tick     = (tick_cnt_ff == TICK_CYCLES - 1);
  wire [25:0]   asym_lhs = dmax * `MSE_PCT_SCALE;
  wire [25:0]   asym_rhs = {10'h000, vrated_ff} * {16'h0000, asym_ff};
  wire          asym_bad = multi_ph && (asym_ff != 10'h000) && (asym_lhs > asym_rhs);
  wire          rot_bad  = multi_ph && (((rot_req == 2'h1) && !rot_cw_i) ||
                                        ((rot_req == 2'h2) && rot_cw_i));
  wire          acc      = psel_i && penable_i;
  wire          wr       = acc && pwrite_i;

  // Per-phase voltage bands and frequency band
  always @* begin
    for (i = 0; i < 3; i = i + 1) begin
      nxt_vband[2*i +: 2] = band(vband_ff[2*i +: 2], volt_i[VW*i +: VW], vpres_ff[15:0], vpres_ff[31:16],
                                 vlim_ff[15:0], vlim_ff[31:16]);
    end
    nxt_fband = band(fband_ff, freq_i, fpres_ff[15:0], fpres_ff[31:16], flim_ff[15:0], flim_ff[31:16]);
  end

  // Global status
  always @* begin
    case (ctrl_ff[`MSE_CTRL_PH_LSB +: 2])
      2'h2:    act = 3'b011;
      2'h3:    act = 3'b111;
      default: act = 3'b001;
    endcase
    all_abs  = (fband_ff == `MSE_ST_ABSENT);
    all_ok   = (fband_ff == `MSE_ST_OK);
    any_high = (fband_ff == `MSE_ST_HIGH);
    for (j = 0; j < 3; j = j + 1) begin
      if (act[j]) begin
        all_abs  = all_abs && (vband_ff[2*j +: 2] == `MSE_ST_ABSENT);
        all_ok   = all_ok && (vband_ff[2*j +: 2] == `MSE_ST_OK);
        any_high = any_high || (vband_ff[2*j +: 2] == `MSE_ST_HIGH);
      end
    end
    dmax = absdiff(volt_i[0 +: VW], volt_i[VW +: VW]);
    if (act[2] && (absdiff(volt_i[VW +: VW], volt_i[2*VW +: VW]) > dmax))
      dmax = absdiff(volt_i[VW +: VW], volt_i[2*VW +: VW]);
    if (act[2] && (absdiff(volt_i[0 +: VW], volt_i[2*VW +: VW]) > dmax))
      dmax = absdiff(volt_i[0 +: VW], volt_i[2*VW +: VW]);
    if (all_abs)
      int_st = `MSE_ST_ABSENT;
    else if (all_ok)
      int_st = (asym_bad || rot_bad) ? `MSE_ST_LOW : `MSE_ST_OK;
    else if (any_high)
      int_st = `MSE_ST_HIGH;
    else
      int_st = `MSE_ST_LOW;
    if (ctrl_ff[`MSE_CTRL_EXT])
      glob_st = external_mains_sensor_input ? `MSE_ST_OK : `MSE_ST_ABSENT;
    else if (vrated_ff == 16'h0000)
      glob_st = `MSE_ST_ABSENT;
    else
      glob_st = int_st;
  end

  // Presence and absence delay machine
  wire use_pres = mode_off_i ? ctrl_ff[`MSE_CTRL_OPT0] :
                  mode_auto_i ? (gen_feeding_i || ctrl_ff[`MSE_CTRL_OPT1]) : 1'b1;
  wire [15:0] pres_dly = use_pres ? dly_ff[15:0] : 16'h0000;
  wire        good_now = (glob_st == `MSE_ST_OK);

  always @* begin
    nxt_state = state_ff;
    nxt_dcnt  = dcnt_ff;
    case (state_ff)
      S_BAD: begin
        if (good_now) begin
          nxt_state = (pres_dly == 16'h0000) ? S_GOOD : S_TO_GOOD;
          nxt_dcnt  = pres_dly;
        end
      end
      S_TO_GOOD: begin
        if (!good_now)
          nxt_state = S_BAD;
        else if (pres_dly == 16'h0000 || (tick && dcnt_ff <= 16'h0001))
          nxt_state = S_GOOD;
        else if (tick)
          nxt_dcnt = dcnt_ff - 16'h0001;
      end
      S_GOOD: begin
        if (!good_now) begin
          nxt_state = (dly_ff[31:16] == 16'h0000) ? S_BAD : S_TO_BAD;
          nxt_dcnt  = dly_ff[31:16];
        end
      end
      S_TO_BAD: begin
        if (good_now)
          nxt_state = S_GOOD;
        else if (tick && dcnt_ff <= 16'h0001)
          nxt_state = S_BAD;
        else if (tick)
          nxt_dcnt = dcnt_ff - 16'h0001;
      end
      default: nxt_state = S_BAD;
    endcase
    if (nxt_state == S_GOOD || nxt_state == S_TO_BAD)
      nxt_class = `MSE_ST_OK;
    else if (glob_st == `MSE_ST_ABSENT)
      nxt_class = `MSE_ST_ABSENT;
    else
      nxt_class = `MSE_ST_LOW;
  end

  // Register read mux
  always @* begin
    rd_hit = 1'b1;
    case (paddr_i)
      `MSE_OFF_CTRL:     rd_mux = {24'h000000, ctrl_ff};
      `MSE_OFF_VRATED:   rd_mux = {16'h0000, vrated_ff};
      `MSE_OFF_ASYM:     rd_mux = {22'h000000, asym_ff};
      `MSE_OFF_VPRES:    rd_mux = vpres_ff;
      `MSE_OFF_VLIM:     rd_mux = vlim_ff;
      `MSE_OFF_FPRES:    rd_mux = fpres_ff;
      `MSE_OFF_FLIM:     rd_mux = flim_ff;
      `MSE_OFF_DLY:      rd_mux = dly_ff;
      `MSE_OFF_STATUS:   rd_mux = {20'h00000, rot_bad, asym_bad, mains_ok_output, flag_delay_to_bad,
                                   flag_mains_good, flag_delay_to_good, flag_mains_bad_or_absent,
                                   flag_mains_present, state_ff, glob_st};
      `MSE_OFF_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_ff};
      `MSE_OFF_IRQ_EN:   rd_mux = {29'h00000000, irq_en_ff};
      `MSE_OFF_IRQ_CLR:  rd_mux = 32'h00000000;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff     <= `MSE_RST_CTRL;
      vrated_ff   <= `MSE_RST_VRATED;
      asym_ff     <= `MSE_RST_ASYM;
      vpres_ff    <= `MSE_RST_VPRES;
      vlim_ff     <= `MSE_RST_VLIM;
      fpres_ff    <= `MSE_RST_FPRES;
      flim_ff     <= `MSE_RST_FLIM;
      dly_ff      <= `MSE_RST_DLY;
      irq_stat_ff <= 3'h0;
      irq_en_ff   <= 3'h0;
      prdata_ff   <= 32'h00000000;
      vband_ff    <= 6'h00;
      fband_ff    <= `MSE_ST_ABSENT;
      state_ff    <= S_BAD;
      dcnt_ff     <= 16'h0000;
      tick_cnt_ff <= 32'h00000000;
      class_ff    <= `MSE_ST_ABSENT;
      evt_ff      <= 3'h0;
    end else begin
      if (psel_i && !penable_i)
        prdata_ff <= rd_mux;
      if (wr) begin
        case (paddr_i)
          `MSE_OFF_CTRL:    ctrl_ff   <= pwdata_i[7:0];
          `MSE_OFF_VRATED:  vrated_ff <= pwdata_i[15:0];
          `MSE_OFF_ASYM:    asym_ff   <= pwdata_i[9:0];
          `MSE_OFF_VPRES:   vpres_ff  <= pwdata_i;
          `MSE_OFF_VLIM:    vlim_ff   <= pwdata_i;
          `MSE_OFF_FPRES:   fpres_ff  <= pwdata_i;
          `MSE_OFF_FLIM:    flim_ff   <= pwdata_i;
          `MSE_OFF_DLY:     dly_ff    <= pwdata_i;
          `MSE_OFF_IRQ_EN:  irq_en_ff <= pwdata_i[2:0];
          default: ;
        endcase
      end
      // New events win over a clear in the same cycle
      irq_stat_ff <= (irq_stat_ff & ~((wr && paddr_i == `MSE_OFF_IRQ_CLR) ? pwdata_i[2:0] : 3'h0)) | evt_ff;
      vband_ff    <= nxt_vband;
      fband_ff    <= nxt_fband;
      state_ff    <= nxt_state;
      dcnt_ff     <= nxt_dcnt;
      tick_cnt_ff <= tick ? 32'h00000000 : tick_cnt_ff + 32'h00000001;
      class_ff    <= nxt_class;
      evt_ff      <= 3'h0;
      if (ctrl_ff[`MSE_CTRL_LOG] && nxt_class != class_ff) begin
        evt_ff[0] <= (nxt_class == `MSE_ST_ABSENT);
        evt_ff[1] <= (nxt_class == `MSE_ST_LOW);
        evt_ff[2] <= (nxt_class == `MSE_ST_OK);
      end
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !rd_hit;
  assign flag_mains_present       = (glob_st != `MSE_ST_ABSENT);
  assign flag_mains_bad_or_absent = (state_ff == S_BAD) || (state_ff == S_TO_GOOD);
  assign flag_delay_to_good       = (state_ff == S_TO_GOOD);
  assign flag_mains_good          = (state_ff == S_GOOD) || (state_ff == S_TO_BAD);
  assign flag_delay_to_bad        = (state_ff == S_TO_BAD);
  assign mains_ok_output          = flag_mains_good;
  assign event_mains_lost       = evt_ff[0];
  assign event_mains_out_of_tol = evt_ff[1];
  assign event_mains_in_tol     = evt_ff[2];
  assign irq_o                  = |(irq_stat_ff & irq_en_ff);
endmodule // mse_mains_eval
`default_nettype wire

// ---- src/mse_defs.vh ----
// Register map, field positions, reset values and timing counts of the mains status evaluator.
// Assumes a 100 MHz system clock and an APB bus with 32-bit data.
`ifndef MSE_DEFS_VH
`define MSE_DEFS_VH

`define MSE_CLK_NS        10
`define MSE_TICK_NS       1000000
`define MSE_TICK_CYC      (`MSE_TICK_NS / `MSE_CLK_NS)

`define MSE_OFF_CTRL      8'h00
`define MSE_OFF_VRATED    8'h04
`define MSE_OFF_ASYM      8'h08
`define MSE_OFF_VPRES     8'h0C
`define MSE_OFF_VLIM      8'h10
`define MSE_OFF_FPRES     8'h14
`define MSE_OFF_FLIM      8'h18
`define MSE_OFF_DLY       8'h1C
`define MSE_OFF_STATUS    8'h20
`define MSE_OFF_IRQ_STAT  8'h24
`define MSE_OFF_IRQ_EN    8'h28
`define MSE_OFF_IRQ_CLR   8'h2C

`define MSE_CTRL_PH_LSB   0
`define MSE_CTRL_ROT_LSB  2
`define MSE_CTRL_OPT0     4
`define MSE_CTRL_OPT1     5
`define MSE_CTRL_LOG      6
`define MSE_CTRL_EXT      7

`define MSE_RST_CTRL      8'h03
`define MSE_RST_VRATED    16'h0190
`define MSE_RST_ASYM      10'h064
`define MSE_RST_VPRES     32'h000A_0050
`define MSE_RST_VLIM      32'h01B8_0140
`define MSE_RST_FPRES     32'h007D_03E8
`define MSE_RST_FLIM      32'h157C_1194
`define MSE_RST_DLY       32'h0001_000A

`define MSE_PCT_SCALE     26'h00003E8

`define MSE_ST_ABSENT     2'h0
`define MSE_ST_LOW        2'h1
`define MSE_ST_OK         2'h2
`define MSE_ST_HIGH       2'h3

`endif

// ---- tb/mse_chk.sv ----
// Output checker for the mains status evaluator, bound into its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module mse_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mains_ok_output,
  input wire logic flag_mains_present,
  input wire logic flag_mains_bad_or_absent,
  input wire logic flag_delay_to_good,
  input wire logic flag_mains_good,
  input wire logic flag_delay_to_bad,
  input wire logic event_mains_lost,
  input wire logic event_mains_in_tol
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ok_flag_a: assert property (mains_ok_output == flag_mains_good)
    else $error("ok output differs from good flag");
  flag_split_a: assert property (flag_mains_good != flag_mains_bad_or_absent)
    else $error("good and bad flags agree");
  to_good_a: assert property (flag_delay_to_good |-> flag_mains_bad_or_absent)
    else $error("delay to good outside bad state");
  to_bad_a: assert property (flag_delay_to_bad |-> flag_mains_good)
    else $error("delay to bad outside good state");
  in_pulse_a: assert property (event_mains_in_tol |=> !event_mains_in_tol)
    else $error("in tolerance event longer than a cycle");
  in_state_a: assert property (event_mains_in_tol |-> mains_ok_output)
    else $error("in tolerance event without good state");
  lost_state_a: assert property (event_mains_lost |-> !mains_ok_output)
    else $error("lost event while good");
  rise_pres_a: assert property ($rose(mains_ok_output) |-> $past(flag_mains_present))
    else $error("good output without mains present");
  fall_delay_a: assert property ($fell(mains_ok_output) |-> $past(flag_delay_to_bad))
    else $error("good output dropped without absence delay");
endmodule // mse_chk
bind mse_mains_eval mse_chk u_chk (.*);
`default_nettype wire

// ---- tb/mse_front.sv ----
// Measurement front end model: three phase voltages, frequency, rotation.
// Assumes the evaluator clock; sel_i picks absent, ok, low, high, asymmetric, reversed or hysteresis-band mains.
`timescale 1ns/1ns
`default_nettype none
module mse_front (
  input  wire logic        clk_i,
  input  wire logic [2:0]  sel_i,
  output var  logic [47:0] volt_o,
  output var  logic [15:0] freq_o,
  output var  logic        rot_cw_o
);
  always @(posedge clk_i) begin
    rot_cw_o <= (sel_i != 3'h5);
    freq_o   <= (sel_i == 3'h0) ? 16'h0000 : 16'h1388;
    case (sel_i)
      3'h0: volt_o <= 48'h0;
      3'h2: volt_o <= {3{16'h012C}};
      3'h3: volt_o <= {3{16'h01CC}};
      // One phase 50 V below the others
      3'h4: volt_o <= {16'h015E, 16'h0190, 16'h0190};
      // All phases inside the hysteresis zone above the low limit
      3'h6: volt_o <= {3{16'h0145}};
      default: volt_o <= {3{16'h0190}};
    endcase
  end
endmodule // mse_front
`default_nettype wire

// ---- tb/mains_status_evaluator_tb.sv ----
// Self-checking bench of the mains status evaluator.
// Assumes the front end model for measurements and an APB master here.
`timescale 1ns/1ns
`default_nettype none
`include "mse_defs.vh"
module mains_status_evaluator_tb;
  logic        clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, ext = 0, moff = 0, mauto = 0, gen = 0, er;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, rd;
  logic [2:0]  sel = 0;
  wire  [31:0] prd;
  wire  [47:0] volt;
  wire  [15:0] freq;
  wire         rdy, err, rot, ok, evl, evo, evi, irq;
  int          n_mismatch = 0, n_checks = 0, nl = 0, no = 0, ni = 0, n, bl, bo, bi;
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    nl += evl;
    no += evo;
    ni += evi;
  end
  mse_front fe (.clk_i(clk_i), .sel_i(sel), .volt_o(volt), .freq_o(freq), .rot_cw_o(rot));
  mse_mains_eval #(.TICK_CYCLES(10)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .volt_i(volt), .freq_i(freq), .rot_cw_i(rot), .external_mains_sensor_input(ext), .mode_off_i(moff),
    .mode_auto_i(mauto), .gen_feeding_i(gen), .mains_ok_output(ok), .flag_mains_present(),
    .flag_mains_bad_or_absent(), .flag_delay_to_good(), .flag_mains_good(), .flag_delay_to_bad(),
    .event_mains_lost(evl), .event_mains_out_of_tol(evo), .event_mains_in_tol(evi), .irq_o(irq));
  task wrap_up;
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk_i);
    pen <= 1;
    k = 0;
    do begin @(posedge clk_i); k++; end while (rdy !== 1'b1 && k < 20);
    rd = prd;
    er = err;
    if (k >= 20) begin n_mismatch++; wrap_up; end
    psel <= 0; pen <= 0;
    @(posedge clk_i);
  endtask
  // Cycles until the good output reaches v, left in n
  task wok(input logic v);
    n = 0;
    do begin @(negedge clk_i); n++; end while (ok !== v && n < 300);
    if (n >= 300) begin n_mismatch++; wrap_up; end
    @(posedge clk_i);
  endtask
  task pres(input logic slow);
    sel <= 0; wok(0);
    sel <= 1; wok(1);
    chk(n > 80, slow, "pres_delay");
  endtask
  task st(input logic [2:0] s, input logic [1:0] e);
    sel <= s; tick(4);
    apb(0, `MSE_OFF_STATUS, 0);
    chk(rd[1:0], e, "glob");
  endtask
  task t_regs;
    apb(0, `MSE_OFF_VRATED, 0); chk(rd, `MSE_RST_VRATED, "vrated");
    apb(0, `MSE_OFF_ASYM, 0); chk(rd, `MSE_RST_ASYM, "asym");
    apb(0, `MSE_OFF_DLY, 0); chk(rd, `MSE_RST_DLY, "dly");
    apb(1, 8'h40, 32'h5); chk(er, 1, "slverr");
  endtask
  task t_irq;
    moff <= 1; apb(1, `MSE_OFF_CTRL, 32'h43); apb(1, `MSE_OFF_IRQ_EN, 32'h4); apb(1, `MSE_OFF_IRQ_CLR, 32'h7);
    chk(irq, 0, "irq_clr");
    sel <= 0; wok(0); sel <= 1; wok(1); tick(3);
    chk(irq, 1, "irq_set");
    apb(1, `MSE_OFF_IRQ_EN, 0); chk(irq, 0, "irq_mask");
    apb(1, `MSE_OFF_IRQ_EN, 32'h4); apb(1, `MSE_OFF_IRQ_CLR, 32'h4); chk(irq, 0, "irq_off");
    apb(0, `MSE_OFF_IRQ_STAT, 0); chk(rd[2], 0, "irq_stat");
  endtask
  task t_off;
    apb(1, `MSE_OFF_CTRL, 32'h43); pres(0);
    apb(1, `MSE_OFF_CTRL, 32'h53); pres(1);
  endtask
  task t_auto;
    moff <= 0; mauto <= 1; apb(1, `MSE_OFF_CTRL, 32'h43); pres(0);
    gen <= 1; pres(1);
    gen <= 0; apb(1, `MSE_OFF_CTRL, 32'h63); pres(1);
  endtask
  task t_ev;
    moff <= 1; apb(1, `MSE_OFF_CTRL, 32'h43); sel <= 1; wok(1);
    bl = nl;
    bo = no;
    bi = ni;
    sel <= 2; wok(0); tick(3); chk(no - bo, 1, "ev_oot");
    sel <= 0; tick(6); chk(nl - bl, 1, "ev_lost");
    sel <= 1; wok(1); tick(2); chk(ni - bi, 1, "ev_in");
    apb(1, `MSE_OFF_CTRL, 32'h03); sel <= 0; wok(0); tick(6); chk(nl - bl, 1, "ev_off");
  endtask
  task t_stat;
    st(0, `MSE_ST_ABSENT);
    st(2, `MSE_ST_LOW);
    st(6, `MSE_ST_LOW);
    st(3, `MSE_ST_HIGH);
    st(4, `MSE_ST_LOW);
    st(1, `MSE_ST_OK);
    st(6, `MSE_ST_OK);
    st(5, `MSE_ST_OK);
    apb(1, `MSE_OFF_CTRL, 32'h07); st(5, `MSE_ST_LOW);
    apb(1, `MSE_OFF_CTRL, 32'h0B); st(1, `MSE_ST_LOW);
    st(5, `MSE_ST_OK);
    apb(1, `MSE_OFF_CTRL, 32'h03); apb(1, `MSE_OFF_ASYM, 32'h7D); st(4, `MSE_ST_OK);
    apb(1, `MSE_OFF_ASYM, 0); st(1, `MSE_ST_OK); st(4, `MSE_ST_OK);
  endtask
  task t_ext;
    apb(1, `MSE_OFF_CTRL, 32'h83); ext <= 1; st(0, `MSE_ST_OK);
    ext <= 0; st(1, `MSE_ST_ABSENT);
    apb(1, `MSE_OFF_CTRL, 32'h03); apb(1, `MSE_OFF_VRATED, 0); st(1, `MSE_ST_ABSENT);
  endtask
  initial begin
    tick(5);
    rst_n_i <= 1;
    tick(1);
    t_regs;
    t_irq;
    t_off;
    t_auto;
    t_ev;
    t_stat;
    t_ext;
    wrap_up;
  end
endmodule // mains_status_evaluator_tb
`default_nettype wire
